// ### src/angrd_consts.vh
`ifndef ANGRD_CONSTS_VH
`define ANGRD_CONSTS_VH
// ***********************************
// register addresses
// ***********************************
`define ANGRD_ADR_ANGLE_STATUS 8'h20
`define ANGRD_ADR_FIELD 8'h2a
`define ANGRD_ADR_ANGLE_HIRES 8'h32
`define ANGRD_ADR_ANGLE_ZCD 8'h2c
`define ANGRD_ADR_WRITE_ADR 8'h3c
// ***********************************
// word layout
// ***********************************
`define ANGRD_BIT_ERR 14
`define ANGRD_BIT_UV 13
`define ANGRD_BIT_PAR 12
`define ANGRD_PAR_ODD 1'b1
// ***********************************
// timing, clock 20 MHz
// ***********************************
`define ANGRD_CLK_KHZ 20000
`define ANGRD_ANG_RATE_KHZ 1000
`define ANGRD_ZCD_US 32
`define ANGRD_FIELD_US 128
`define ANGRD_ANG_CYC (`ANGRD_CLK_KHZ / `ANGRD_ANG_RATE_KHZ)
`define ANGRD_ZCD_CYC (`ANGRD_ZCD_US * `ANGRD_CLK_KHZ / 1000)
`define ANGRD_FIELD_CYC (`ANGRD_FIELD_US * `ANGRD_CLK_KHZ / 1000)
`define ANGRD_NVM_WORDS 4
`define ANGRD_NVM_ZERO 2'h0
`define ANGRD_SPI_BITS 16
`endif

// ### src/angrd_nvm.v
// ***********************************
// small non-volatile store model, registered read
// ***********************************
module angrd_nvm #(
    parameter AW = 2,
    parameter DW = 16
) (
    // clock
    input wire i_clk,
    // access
    input wire [AW-1:0] i_adr,
    input wire i_we,
    input wire [DW-1:0] i_wdata,
    output reg [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_adr] <= i_wdata;
        end
        o_rdata <= mem[i_adr];
    end
endmodule

// ### src/angrd_sync.v
// ***********************************
// three-stage input synchroniser
// ***********************************
module angrd_sync #(
    parameter W = 1
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [W-1:0] i_d,
    output reg [W-1:0] o_q,
    output wire o_stable
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    // change counts only once stages two and three agree
    assign o_stable = (s2_r == s3_r);
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            o_q <= {W{1'b0}};
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                o_q <= s3_r;
            end
        end
    end
endmodule

// ### src/angrd_top.v
// Operation
// - the main angle register takes a new processed sample once per 1 us.
// - address 0x20 returns zero, error, undervoltage, parity and the 12-bit angle.
// - address 0x32 returns zero over the 15-bit angle.
// - each 12-bit angle read carries error, undervoltage and parity bits.
// - the pulse-width path takes 12 bits, the encoder path 15 bits.
// - the reported angle is offset by a zero position held in non-volatile store.
// - the returned word is captured at the first serial clock edge of the frame.
// - the pulse-width angle is sampled at each carrier start and held a period.
// - the secondary path angle register refreshes every 32 us.
// - the field strength register refreshes every 128 us.
// - at power-up the zero position reloads from non-volatile store.
// - after power-up serial registers are at defaults, write address zero.
// - a separate low-power path supplies turns and a diagnostic angle.
// - the undervoltage flag is set while supply is below range.
`include "angrd_consts.vh"
module angrd_top #(
    parameter ANG_CYC = `ANGRD_ANG_CYC,
    parameter ZCD_CYC = `ANGRD_ZCD_CYC,
    parameter FIELD_CYC = `ANGRD_FIELD_CYC
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // processed front-end results
    input wire [14:0] i_raw_angle,
    input wire [14:0] i_zcd_raw_angle,
    input wire [15:0] i_field_raw,
    input wire i_err,
    input wire i_uv_det,
    // serial port pins, host clocked
    input wire i_sclk,
    input wire i_cs_n,
    input wire i_mosi,
    output reg o_miso,
    output reg o_miso_oe,
    // output path angles
    input wire i_pwm_period_start,
    output reg [11:0] o_pwm_angle,
    output reg [14:0] o_enc_angle,
    // low-power path results
    output reg [14:0] o_zcd_angle,
    output reg o_zcd_turn,
    // zero offset store write
    input wire i_nvm_we,
    input wire [15:0] i_nvm_wdata,
    output reg o_init_done
);
    // ***********************************
    // pin synchronisers
    // ***********************************
    wire [2:0] pin_q;
    angrd_sync #(.W(3)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d({i_sclk, i_cs_n, i_mosi}),
        .o_q(pin_q),
        .o_stable()
    );
    wire sclk_s = pin_q[2];
    wire cs_n_s = pin_q[1];
    wire mosi_s = pin_q[0];
    reg sclk_d_r;
    reg cs_n_d_r;
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;
    wire frame_start = ~cs_n_s & cs_n_d_r;
    // ***********************************
    // power-up reload
    // ***********************************
    localparam S_INIT = 2'd0;
    localparam S_WAIT = 2'd1;
    localparam S_RUN = 2'd2;
    reg [1:0] state_r;
    reg [14:0] zero_r;
    wire [15:0] nvm_rdata;
    angrd_nvm #(.AW(2), .DW(16)) u_nvm (
        .i_clk(i_clk),
        .i_adr(`ANGRD_NVM_ZERO),
        .i_we(i_nvm_we),
        .i_wdata(i_nvm_wdata),
        .o_rdata(nvm_rdata)
    );
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= S_INIT;
            zero_r <= 15'h0000;
            o_init_done <= 1'b0;
        end else begin
            case (state_r)
                S_INIT: state_r <= S_WAIT;
                S_WAIT: begin
                    zero_r <= nvm_rdata[14:0];
                    o_init_done <= 1'b1;
                    state_r <= S_RUN;
                end
                S_RUN: begin
                    // a write relocates zero at once
                    if (i_nvm_we) begin
                        zero_r <= i_nvm_wdata[14:0];
                    end
                end
                default: state_r <= S_INIT;
            endcase
        end
    end
    // ***********************************
    // refresh timers
    // ***********************************
    reg [15:0] ang_cnt_r;
    reg [15:0] zcd_cnt_r;
    reg [15:0] fld_cnt_r;
    reg [14:0] angle_r;
    reg [15:0] field_r;
    reg err_r;
    reg uv_r;
    wire [14:0] ang_adj = i_raw_angle - zero_r;
    wire [14:0] zcd_adj = i_zcd_raw_angle - zero_r;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            ang_cnt_r <= 16'h0000;
            zcd_cnt_r <= 16'h0000;
            fld_cnt_r <= 16'h0000;
            angle_r <= 15'h0000;
            field_r <= 16'h0000;
            o_zcd_angle <= 15'h0000;
            o_zcd_turn <= 1'b0;
            err_r <= 1'b0;
            uv_r <= 1'b0;
        end else begin
            err_r <= i_err;
            uv_r <= i_uv_det;
            if (ang_cnt_r == ANG_CYC - 1) begin
                ang_cnt_r <= 16'h0000;
                angle_r <= ang_adj;
            end else begin
                ang_cnt_r <= ang_cnt_r + 16'h0001;
            end
            if (zcd_cnt_r == ZCD_CYC - 1) begin
                zcd_cnt_r <= 16'h0000;
                o_zcd_angle <= zcd_adj;
                // turn flag on wrap through zero
                o_zcd_turn <= (o_zcd_angle[14:13] == 2'b11) && (zcd_adj[14:13] == 2'b00);
            end else begin
                zcd_cnt_r <= zcd_cnt_r + 16'h0001;
            end
            if (fld_cnt_r == FIELD_CYC - 1) begin
                fld_cnt_r <= 16'h0000;
                field_r <= i_field_raw;
            end else begin
                fld_cnt_r <= fld_cnt_r + 16'h0001;
            end
        end
    end
    // ***********************************
    // output path angles
    // ***********************************
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pwm_angle <= 12'h000;
            o_enc_angle <= 15'h0000;
        end else begin
            o_enc_angle <= angle_r;
            if (i_pwm_period_start) begin
                o_pwm_angle <= angle_r[14:3];
            end
        end
    end
    // ***********************************
    // serial read port
    // ***********************************
    reg [7:0] cmd_r;
    reg [7:0] adr_r;
    reg [7:0] write_adr_r;
    reg [15:0] shift_r;
    reg [4:0] bit_cnt_r;
    reg first_r;
    reg frame_odd_r;
    wire [11:0] a12 = angle_r[14:3];
    wire par = ~^{1'b0, err_r, uv_r, a12} ^ ~`ANGRD_PAR_ODD;
    reg [15:0] rd_word;
    always @* begin
        case (adr_r)
            `ANGRD_ADR_ANGLE_STATUS: rd_word = {1'b0, err_r, uv_r, par, a12};
            `ANGRD_ADR_ANGLE_HIRES: rd_word = {1'b0, angle_r};
            `ANGRD_ADR_FIELD: rd_word = field_r;
            `ANGRD_ADR_ANGLE_ZCD: rd_word = {1'b0, o_zcd_angle};
            `ANGRD_ADR_WRITE_ADR: rd_word = {8'h00, write_adr_r};
            default: rd_word = 16'h0000;
        endcase
    end
    // every frame carries a command and returns the word for the address set by the last full frame with command bit 7 clear
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
            cmd_r <= 8'h00;
            adr_r <= 8'h00;
            write_adr_r <= 8'h00;
            shift_r <= 16'h0000;
            bit_cnt_r <= 5'd0;
            first_r <= 1'b0;
            frame_odd_r <= 1'b0;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
            o_miso_oe <= ~cs_n_s;
            if (frame_start) begin
                bit_cnt_r <= 5'd0;
                first_r <= 1'b1;
            end else if (cs_n_s & ~cs_n_d_r) begin
                // frame end: a full frame sets the next read, or the write address if command bit 7 is set
                if (bit_cnt_r == `ANGRD_SPI_BITS) begin
                    if (cmd_r[7]) begin
                        write_adr_r <= cmd_r;
                    end else begin
                        adr_r <= cmd_r;
                    end
                end
                frame_odd_r <= ~frame_odd_r;
            end else if (~cs_n_s) begin
                if (first_r & (sclk_rise | sclk_fall)) begin
                    first_r <= 1'b0;
                    shift_r <= {rd_word[14:0], 1'b0};
                    o_miso <= rd_word[15];
                end else if (sclk_fall) begin
                    o_miso <= shift_r[15];
                    shift_r <= {shift_r[14:0], 1'b0};
                end
                if (sclk_rise) begin
                    bit_cnt_r <= bit_cnt_r + 5'd1;
                    if (bit_cnt_r < 5'd8) begin
                        cmd_r <= {cmd_r[6:0], mosi_s};
                    end
                end
            end
        end
    end
endmodule

// ### bench/angrd_chk_sva.sv
// ****************************************
// serial pin and output path checks
// ****************************************
module angrd_chk #(parameter ANG_CYC = 4, parameter ZCD_CYC = 8, parameter FIELD_CYC = 16) (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // serial pins
    input wire i_sclk,
    input wire i_cs_n,
    input wire o_miso,
    input wire o_miso_oe,
    // output paths
    input wire i_pwm_period_start,
    input wire [11:0] o_pwm_angle,
    input wire [14:0] o_enc_angle,
    input wire [14:0] o_zcd_angle,
    input wire o_init_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk_q;
    logic [3:0] sclk_age;
    // serial clock is async, so allow for sync depth
    always @(posedge i_clk) begin
        sclk_q <= i_sclk;
        if (!i_rst_n || sclk_q != i_sclk) begin
            sclk_age <= 4'h0;
        end else if (sclk_age != 4'hf) begin
            sclk_age <= sclk_age + 4'h1;
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_sel;
        $fell(i_cs_n);
    endsequence
    sequence s_oe_up;
        ##[2:6] o_miso_oe;
    endsequence
    AST_RST_OUT: assert property (disable iff (1'h0) !i_rst_n |=> !o_init_done && !o_miso_oe)
        else $error("outputs not cleared by reset");
    AST_INIT_UP: assert property ($rose(i_rst_n) |-> !o_init_done ##[1:3] o_init_done)
        else $error("reload did not finish in time");
    AST_INIT_HOLD: assert property (o_init_done |=> o_init_done)
        else $error("reload flag dropped");
    AST_ENC_RATE: assert property ($changed(o_enc_angle) |=> $stable(o_enc_angle) [*3])
        else $error("main angle refreshed too often");
    AST_PWM_HOLD: assert property (!i_pwm_period_start [*3] |=> $stable(o_pwm_angle))
        else $error("pulse-width angle moved within a period");
    AST_ZCD_RATE: assert property ($changed(o_zcd_angle) |=> $stable(o_zcd_angle) [*6])
        else $error("secondary angle refreshed too often");
    AST_OE_ON: assert property (s_sel |-> s_oe_up)
        else $error("data output not enabled after select");
    AST_OE_OFF: assert property ($rose(i_cs_n) |-> ##[2:6] !o_miso_oe)
        else $error("data output not released after deselect");
    AST_OE_IDLE: assert property (i_cs_n [*8] |-> !o_miso_oe)
        else $error("data output driven while deselected");
    AST_MISO_EDGE: assert property ($changed(o_miso) && !i_cs_n |-> sclk_age < 4'h8)
        else $error("data output moved without a serial clock edge");
endmodule
bind angrd_top angrd_chk #(.ANG_CYC(ANG_CYC), .ZCD_CYC(ZCD_CYC), .FIELD_CYC(FIELD_CYC)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_pwm_period_start(i_pwm_period_start), .o_pwm_angle(o_pwm_angle),
    .o_enc_angle(o_enc_angle), .o_zcd_angle(o_zcd_angle), .o_init_done(o_init_done)
);

// ### bench/angrd_host.sv
// ****************************************
// host serial master
// ****************************************
module angrd_host (
    // serial pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_mosi = 1'h0;
    end
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        // step off the clock edge so pin changes never race the sync flops
        #10;
        o_cs_n = 1'h0;
        #400;
        for (int i = 15; i >= 0; i--) begin
            o_mosi = tx[i];
            #100 o_sclk = 1'h1;
            #200 o_sclk = 1'h0;
            // mid low phase, clear of the sync lag
            #100 rx[i] = i_miso;
        end
        #200 o_cs_n = 1'h1;
        o_mosi = ~o_mosi;
        #800;
    endtask
endmodule

// ### bench/angrd_top_test.sv
module angrd_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic [14:0] raw = 15'h0000;
    logic [14:0] zraw = 15'h0000;
    logic [15:0] field = 16'h0000;
    logic err = 1'h0;
    logic uv = 1'h0;
    logic pst = 1'h0;
    logic nwe = 1'h0;
    logic [15:0] nwd = 16'h0000;
    wire sclk, cs_n, mosi, miso, oe, zturn, idone;
    wire [11:0] pwm;
    wire [14:0] enc, zang;
    logic [15:0] d;
    int num_errors = 0;
    int checked = 0;
    always #25 i_clk = ~i_clk;
    angrd_top #(.ANG_CYC(4), .ZCD_CYC(8), .FIELD_CYC(16)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_raw_angle(raw), .i_zcd_raw_angle(zraw),
        .i_field_raw(field), .i_err(err), .i_uv_det(uv), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .i_pwm_period_start(pst),
        .o_pwm_angle(pwm), .o_enc_angle(enc), .o_zcd_angle(zang), .o_zcd_turn(zturn),
        .i_nvm_we(nwe), .i_nvm_wdata(nwd), .o_init_done(idone)
    );
    angrd_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(oe ? miso : 1'hz));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic rst_run();
        @(posedge i_clk);
        i_rst_n <= 1'h0;
        cyc(4);
        i_rst_n <= 1'h1;
        for (int i = 0; i < 10 && idone !== 1'h1; i++) begin
            @(posedge i_clk);
        end
        if (idone !== 1'h1) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic nvm_wr(input logic [15:0] v);
        @(posedge i_clk);
        nwe <= 1'h1;
        nwd <= v;
        @(posedge i_clk);
        nwe <= 1'h0;
    endtask
    // answer arrives in the frame after the command
    task automatic rd(input logic [7:0] adr);
        host.xfer({adr, 8'h00}, d);
        host.xfer({adr, 8'h00}, d);
        @(posedge i_clk);
    endtask
    function automatic logic [15:0] w12(input logic e, input logic u, input logic [14:0] a);
        logic p;
        p = ~^{e, u, a[14:3]};
        return {1'h0, e, u, p, a[14:3]};
    endfunction
    initial begin
        rst_run();
        nvm_wr(16'h0000);
        rst_run();
        raw <= 15'h1234;
        field <= 16'hbeef;
        cyc(40);
        rd(8'h32);
        cmp(d, 16'h1234);
        rd(8'h2a);
        cmp(d, 16'hbeef);
        rd(8'h10);
        cmp(d, 16'h0000);
        $display("test plain reads done");
        for (int k = 0; k < 4; k++) begin
            err <= k[1];
            uv <= k[0];
            raw <= 15'h7ff8 ^ 15'(k << 3);
            cyc(10);
            rd(8'h20);
            cmp(d, w12(k[1], k[0], 15'h7ff8 ^ 15'(k << 3)));
        end
        $display("test status word done");
        raw <= 15'h2468;
        cyc(10);
        pst <= 1'h1;
        cyc(1);
        pst <= 1'h0;
        raw <= 15'h1357;
        cyc(20);
        cmp({4'h0, pwm}, 16'h048d);
        cmp({1'h0, enc}, 16'h1357);
        $display("test output paths done");
        zraw <= 15'h7000;
        cyc(20);
        cmp({1'h0, zang}, 16'h7000);
        zraw <= 15'h0800;
        for (int i = 0; i < 30 && zang !== 15'h0800; i++) begin
            @(posedge i_clk);
        end
        cmp({1'h0, zang}, 16'h0800);
        cmp({15'h0000, zturn}, 16'h0001);
        cyc(20);
        cmp({15'h0000, zturn}, 16'h0000);
        $display("test secondary path done");
        raw <= 15'h0abc;
        cyc(10);
        host.xfer(16'h3200, d);
        fork
            host.xfer(16'h3200, d);
            begin
                #2000;
                @(posedge i_clk) raw <= 15'h0123;
            end
        join
        cmp(d, 16'h0abc);
        $display("test mid-frame update done");
        nvm_wr(16'h0100);
        rst_run();
        raw <= 15'h0050;
        cyc(10);
        rd(8'h32);
        cmp(d, 16'h7f50);
        rd(8'h3c);
        cmp(d, 16'h0000);
        $display("test zero offset reload done");
        finish_test();
    end
endmodule
